/* File: inc/ftab_map.svh */
// What this block does
// (RULE1) Eight-bit latch: loaded by reads, sourced by writes.
// (RULE2) Table read puts addressed flash byte into latch.
// (RULE3) Table write fills buffer RAM, never flash.
// (RULE4) Pointer low byte picks buffer slot on writes.
// (RULE5) Byte granular access, no alignment needed.
// (RULE6) Software keeps written instructions word aligned.
// (RULE7) Table read uses all 22 pointer bits.
// (RULE8) Buffer is 256 bytes; high bits ignored.
// (RULE9) Page write commits buffer at address upper bits.
// (RULE10) One byte per read; optional pointer stepping.
// (RULE11) Core stalls during read; latch valid next.
// (RULE12) Flash is 16-bit words; bit 0 picks byte.
// (RULE13) Data flash sits above program flash, both paths.
// (RULE14) Data flash byte access via data, address registers.
// (RULE15) Data flash byte write erases then programs.
// (RULE16) Internal timer sets data flash write length.
// (RULE17) Byte read result ready next cycle after start; the code waits for flash_rvalid_in instead.
// (RULE18) Data register holds until read or write.
// (RULE19) Page read to data flash is refused.
// (RULE20) Read completion clears start and raises flag.
// (RULE21) Pointer stepping touches bits 0 to 20 only.
// (RULE22) Pointer bit 21 selects configuration and ID space.
// (RULE23) Even address low byte, odd address high byte.
// (RULE24) Table write changes only the addressed byte.
`ifndef FTAB_MAP_SVH
`define FTAB_MAP_SVH

// =====================================================================
// Widths and field positions.
`define FT_PTR_W 22
`define FT_STEP_W 21
`define FT_SPACE_BIT 21
`define FT_BSEL_BIT 0
`define FT_BYTE_W 8
`define FT_WORD_W 16
`define FT_PAGE_AW 8
`define FT_PAGE_CNT_W 9
`define FT_PAGE_BYTES 9'h100
`define FT_UPPER_W 6
`define FT_SEL_W 4

// =====================================================================
// Command codes and map boundary.
`define FT_CMD_W 3
`define FT_CMD_READ 3'h0
`define FT_CMD_READ_INC 3'h1
`define FT_CMD_PAGE_READ 3'h2
`define FT_CMD_BYTE_WRITE 3'h3
`define FT_CMD_PAGE_WRITE 3'h5
`define FT_DFM_BASE 22'h380000

// =====================================================================
// Reset values.
`define FT_RST_BYTE 8'h00
`define FT_RST_PTR 22'h000000
`define FT_RST_CMD 3'h0

// =====================================================================
// Timing: data flash write time in ns and its cycle count.
`define FT_CLK_NS 10
`define FT_DFM_WR_NS 10000
`define FT_TMR_W 10
`define FT_DFM_WR_CYC ((`FT_DFM_WR_NS + `FT_CLK_NS - 1) / `FT_CLK_NS)

`endif

/* File: inc/ftab_pkg.sv */
`include "ftab_map.svh"

package ftab_pkg;

  // =====================================================================
  // Pointer stepping of a table instruction.
  typedef enum logic [1:0] {
    FT_PM_NONE,
    FT_PM_POSTINC,
    FT_PM_POSTDEC,
    FT_PM_PREINC
  } ftab_pmode_t;

  // Register selected by a core write.
  typedef enum logic [`FT_SEL_W-1:0] {
    FT_SEL_LATCH,
    FT_SEL_PTR_LOW,
    FT_SEL_PTR_HIGH,
    FT_SEL_PTR_UPPER,
    FT_SEL_ADR_LOW,
    FT_SEL_ADR_HIGH,
    FT_SEL_ADR_UPPER,
    FT_SEL_DATA_LOW,
    FT_SEL_CMD,
    FT_SEL_GO
  } ftab_sel_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    FT_ST_IDLE,
    FT_ST_TRD,
    FT_ST_NRD,
    FT_ST_DWR,
    FT_ST_PGW
  } ftab_state_t;

  // Table instruction issued by the core.
  typedef struct packed {
    logic valid;
    logic write;
    ftab_pmode_t mode;
  } ftab_tbl_req_t;

  // Register write issued by the core.
  typedef struct packed {
    logic en;
    ftab_sel_t sel;
    logic [`FT_BYTE_W-1:0] data;
  } ftab_sfr_wr_t;

  // Byte write toward the flash array.
  typedef struct packed {
    logic en;
    logic erase;
    logic [`FT_PTR_W-1:0] addr;
    logic [`FT_BYTE_W-1:0] data;
  } ftab_flash_wr_t;

endpackage

/* File: rtl/ftab_wbuf.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftab_map.svh"

// =====================================================================
// Write buffer RAM with one write port and a registered read port.
module ftab_wbuf (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [`FT_PAGE_AW-1:0] wr_addr_in,
  input wire logic [`FT_BYTE_W-1:0] wr_data_in,
  input wire logic [`FT_PAGE_AW-1:0] rd_addr_in,
  output logic [`FT_BYTE_W-1:0] rd_data_out
);

  logic [`FT_BYTE_W-1:0] mem_r [0:(1<<`FT_PAGE_AW)-1];

  // Only the addressed byte changes; all others keep their contents.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in; // see RULE24
    end
  end

  // Read data comes out of a register one cycle after the address.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= `FT_RST_BYTE;
    end else begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule // ftab_wbuf
`default_nettype wire

/* File: rtl/ftab_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftab_map.svh"

// =====================================================================
// Table access path and data flash byte read between core and flash.
module ftab_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire ftab_pkg::ftab_tbl_req_t tbl_req_in,
  input wire ftab_pkg::ftab_sfr_wr_t sfr_wr_in,
  input wire logic flag_clr_in,
  input wire logic [`FT_WORD_W-1:0] flash_rdata_in,
  input wire logic flash_rvalid_in,
  output logic cpu_stall_out,
  output logic [`FT_BYTE_W-1:0] table_byte_latch_out,
  output logic [`FT_PTR_W-1:0] table_byte_pointer_out,
  output logic [`FT_PTR_W-1:0] nv_address_reg_out,
  output logic [`FT_BYTE_W-1:0] nv_data_low_reg_out,
  output logic [`FT_CMD_W-1:0] nv_command_field_out,
  output logic nv_go_out,
  output logic nv_done_irq_flag_out,
  output logic nv_write_error_out,
  output logic flash_rd_req_out,
  output logic [`FT_PTR_W-2:0] flash_rd_addr_out,
  output ftab_pkg::ftab_flash_wr_t flash_wr_out
);

  // =====================================================================
  // State.
  ftab_pkg::ftab_state_t state_r, state_nxt;
  logic stall_r, stall_nxt;
  logic [`FT_BYTE_W-1:0] latch_r, latch_nxt;
  logic [`FT_PTR_W-1:0] ptr_r, ptr_nxt;
  logic bsel_r, bsel_nxt;
  logic [`FT_PTR_W-1:0] nv_addr_r, nv_addr_nxt;
  logic [`FT_BYTE_W-1:0] nv_data_r, nv_data_nxt;
  logic [`FT_CMD_W-1:0] nv_cmd_r, nv_cmd_nxt;
  logic go_r, go_nxt;
  logic flag_r, flag_nxt;
  logic err_r, err_nxt;
  logic frd_req_r, frd_req_nxt;
  logic [`FT_PTR_W-2:0] frd_addr_r, frd_addr_nxt;
  ftab_pkg::ftab_flash_wr_t fwr_r, fwr_nxt;
  logic [`FT_TMR_W-1:0] tmr_r, tmr_nxt;
  logic [`FT_PAGE_CNT_W-1:0] cnt_r, cnt_nxt;

  logic [`FT_PTR_W-1:0] eff_ptr;
  logic [`FT_PTR_W-1:0] post_ptr;
  logic tbl_acc;
  logic tbl_rd_acc;
  logic tbl_wr_acc;
  logic go_acc;
  logic is_dfm;
  logic flag_set;
  logic [`FT_PAGE_AW-1:0] wb_rd_addr;
  logic [`FT_BYTE_W-1:0] wb_rd_data;

  // Steps the pointer by one, leaving the space select bit alone.
  function automatic logic [`FT_PTR_W-1:0] ptr_step(input logic [`FT_PTR_W-1:0] p,
                                                    input logic up);
    logic [`FT_STEP_W-1:0] low;
    low = p[`FT_STEP_W-1:0];
    if (up) begin
      low = low + `FT_STEP_W'(1); // see RULE21
    end else begin
      low = low - `FT_STEP_W'(1); // see RULE21
    end
    ptr_step = {p[`FT_SPACE_BIT], low}; // see RULE22
  endfunction

  // =====================================================================
  // Request decode and pointer arithmetic.
  always_comb begin
    eff_ptr = ptr_r;
    if (tbl_req_in.mode == ftab_pkg::FT_PM_PREINC) begin
      eff_ptr = ptr_step(ptr_r, 1'b1);
    end
    post_ptr = eff_ptr;
    if (tbl_req_in.mode == ftab_pkg::FT_PM_POSTINC) begin
      post_ptr = ptr_step(eff_ptr, 1'b1); // see RULE10
    end else if (tbl_req_in.mode == ftab_pkg::FT_PM_POSTDEC) begin
      post_ptr = ptr_step(eff_ptr, 1'b0);
    end
  end

  // Table operations are taken only while the sequencer rests.
  assign tbl_acc = tbl_req_in.valid && (state_r == ftab_pkg::FT_ST_IDLE);
  assign tbl_rd_acc = tbl_acc && !tbl_req_in.write;
  assign tbl_wr_acc = tbl_acc && tbl_req_in.write;
  assign go_acc = sfr_wr_in.en && (sfr_wr_in.sel == ftab_pkg::FT_SEL_GO) &&
                  sfr_wr_in.data[0] && !go_r && !tbl_req_in.valid &&
                  (state_r == ftab_pkg::FT_ST_IDLE);
  // Data flash occupies the addresses above program flash.
  assign is_dfm = (nv_addr_r >= `FT_DFM_BASE); // see RULE13
  // Page write reads the buffer one byte ahead of each flash write.
  assign wb_rd_addr = cnt_r[`FT_PAGE_AW-1:0];

  // =====================================================================
  // Write buffer: a table write stores the latch at the pointer low byte.
  ftab_wbuf u_wbuf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(tbl_wr_acc), // see RULE3
    .wr_addr_in(eff_ptr[`FT_PAGE_AW-1:0]), // see RULE4
    .wr_data_in(latch_r), // see RULE1
    .rd_addr_in(wb_rd_addr),
    .rd_data_out(wb_rd_data)
  );

  // =====================================================================
  // Next values of the sequencer and all registers.
  always_comb begin
    state_nxt = state_r;
    stall_nxt = stall_r;
    latch_nxt = latch_r;
    ptr_nxt = ptr_r;
    bsel_nxt = bsel_r;
    nv_addr_nxt = nv_addr_r;
    nv_data_nxt = nv_data_r;
    nv_cmd_nxt = nv_cmd_r;
    go_nxt = go_r;
    err_nxt = err_r;
    frd_req_nxt = 1'b0;
    frd_addr_nxt = frd_addr_r;
    fwr_nxt = fwr_r;
    fwr_nxt.en = 1'b0;
    tmr_nxt = tmr_r;
    cnt_nxt = cnt_r;
    flag_set = 1'b0;
    // Core register writes; the NVM registers are frozen while busy.
    if (sfr_wr_in.en && !tbl_acc && !stall_r) begin
      unique case (sfr_wr_in.sel)
        ftab_pkg::FT_SEL_LATCH: latch_nxt = sfr_wr_in.data;
        ftab_pkg::FT_SEL_PTR_LOW: ptr_nxt[7:0] = sfr_wr_in.data;
        ftab_pkg::FT_SEL_PTR_HIGH: ptr_nxt[15:8] = sfr_wr_in.data;
        ftab_pkg::FT_SEL_PTR_UPPER: ptr_nxt[21:16] = sfr_wr_in.data[`FT_UPPER_W-1:0];
        default: begin
        end
      endcase
      if (!go_r) begin
        unique case (sfr_wr_in.sel)
          ftab_pkg::FT_SEL_ADR_LOW: nv_addr_nxt[7:0] = sfr_wr_in.data;
          ftab_pkg::FT_SEL_ADR_HIGH: nv_addr_nxt[15:8] = sfr_wr_in.data;
          ftab_pkg::FT_SEL_ADR_UPPER: nv_addr_nxt[21:16] = sfr_wr_in.data[`FT_UPPER_W-1:0];
          ftab_pkg::FT_SEL_DATA_LOW: nv_data_nxt = sfr_wr_in.data; // see RULE18
          ftab_pkg::FT_SEL_CMD: nv_cmd_nxt = sfr_wr_in.data[`FT_CMD_W-1:0];
          default: begin
          end
        endcase
      end
    end
    unique case (state_r)
      ftab_pkg::FT_ST_IDLE: begin
        if (tbl_rd_acc) begin
          // Word address from all pointer bits, byte picked later.
          frd_req_nxt = 1'b1;
          frd_addr_nxt = eff_ptr[`FT_PTR_W-1:1]; // see RULE7
          bsel_nxt = eff_ptr[`FT_BSEL_BIT]; // see RULE12
          stall_nxt = 1'b1; // see RULE11
          ptr_nxt = post_ptr;
          state_nxt = ftab_pkg::FT_ST_TRD;
        end else if (tbl_wr_acc) begin
          ptr_nxt = post_ptr; // see RULE5
        end else if (go_acc) begin
          go_nxt = 1'b1;
          if ((nv_cmd_r == `FT_CMD_READ) || (nv_cmd_r == `FT_CMD_READ_INC)) begin
            frd_req_nxt = 1'b1;
            frd_addr_nxt = nv_addr_r[`FT_PTR_W-1:1]; // see RULE14
            bsel_nxt = nv_addr_r[`FT_BSEL_BIT];
            state_nxt = ftab_pkg::FT_ST_NRD; // see RULE17
          end else if (nv_cmd_r == `FT_CMD_BYTE_WRITE && is_dfm) begin
            fwr_nxt.en = 1'b1;
            fwr_nxt.erase = 1'b1; // see RULE15
            fwr_nxt.addr = nv_addr_r;
            fwr_nxt.data = nv_data_r;
            tmr_nxt = `FT_TMR_W'(`FT_DFM_WR_CYC); // see RULE16
            state_nxt = ftab_pkg::FT_ST_DWR;
          end else if (nv_cmd_r == `FT_CMD_PAGE_WRITE && !is_dfm) begin
            cnt_nxt = '0;
            state_nxt = ftab_pkg::FT_ST_PGW;
          end else begin
            // Page operations aimed at data flash fail with the error set.
            if (is_dfm) begin
              err_nxt = 1'b1; // see RULE19
            end
            go_nxt = 1'b0;
          end
        end
      end
      ftab_pkg::FT_ST_TRD: begin
        if (flash_rvalid_in) begin
          // Odd address takes the high byte of the word.
          latch_nxt = bsel_r ? flash_rdata_in[15:8] : flash_rdata_in[7:0]; // see RULE2, RULE23
          stall_nxt = 1'b0;
          state_nxt = ftab_pkg::FT_ST_IDLE;
        end
      end
      ftab_pkg::FT_ST_NRD: begin
        if (flash_rvalid_in) begin
          nv_data_nxt = bsel_r ? flash_rdata_in[15:8] : flash_rdata_in[7:0]; // see RULE14
          if (nv_cmd_r == `FT_CMD_READ_INC) begin
            nv_addr_nxt = nv_addr_r + `FT_PTR_W'(1);
          end
          go_nxt = 1'b0; // see RULE20
          flag_set = 1'b1;
          state_nxt = ftab_pkg::FT_ST_IDLE;
        end
      end
      ftab_pkg::FT_ST_DWR: begin
        if (tmr_r == '0) begin
          go_nxt = 1'b0;
          flag_set = 1'b1;
          state_nxt = ftab_pkg::FT_ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - `FT_TMR_W'(1);
        end
      end
      ftab_pkg::FT_ST_PGW: begin
        // Byte cnt-1 leaves the buffer register while byte cnt is read.
        if (cnt_r != '0) begin
          fwr_nxt.en = 1'b1;
          fwr_nxt.erase = 1'b0;
          fwr_nxt.addr = {nv_addr_r[`FT_PTR_W-1:`FT_PAGE_AW],
                          wb_rd_addr - `FT_PAGE_AW'(1)}; // see RULE9
          fwr_nxt.data = wb_rd_data;
        end
        if (cnt_r == `FT_PAGE_BYTES) begin
          go_nxt = 1'b0;
          flag_set = 1'b1;
          state_nxt = ftab_pkg::FT_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + `FT_PAGE_CNT_W'(1); // see RULE8
        end
      end
    endcase
    // A completion in the clearing cycle keeps the flag set.
    flag_nxt = flag_set || (flag_r && !flag_clr_in); // see RULE20
  end

  // =====================================================================
  // Registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ftab_pkg::FT_ST_IDLE;
      stall_r <= 1'b0;
      latch_r <= `FT_RST_BYTE;
      ptr_r <= `FT_RST_PTR;
      bsel_r <= 1'b0;
      nv_addr_r <= `FT_RST_PTR;
      nv_data_r <= `FT_RST_BYTE;
      nv_cmd_r <= `FT_RST_CMD;
      go_r <= 1'b0;
      flag_r <= 1'b0;
      err_r <= 1'b0;
      frd_req_r <= 1'b0;
      frd_addr_r <= '0;
      fwr_r <= '0;
      tmr_r <= '0;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      stall_r <= stall_nxt;
      latch_r <= latch_nxt;
      ptr_r <= ptr_nxt;
      bsel_r <= bsel_nxt;
      nv_addr_r <= nv_addr_nxt;
      nv_data_r <= nv_data_nxt;
      nv_cmd_r <= nv_cmd_nxt;
      go_r <= go_nxt;
      flag_r <= flag_nxt;
      err_r <= err_nxt;
      frd_req_r <= frd_req_nxt;
      frd_addr_r <= frd_addr_nxt;
      fwr_r <= fwr_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Outputs straight from the registers.
  assign cpu_stall_out = stall_r;
  assign table_byte_latch_out = latch_r;
  assign table_byte_pointer_out = ptr_r;
  assign nv_address_reg_out = nv_addr_r;
  assign nv_data_low_reg_out = nv_data_r;
  assign nv_command_field_out = nv_cmd_r;
  assign nv_go_out = go_r;
  assign nv_done_irq_flag_out = flag_r;
  assign nv_write_error_out = err_r;
  assign flash_rd_req_out = frd_req_r;
  assign flash_rd_addr_out = frd_addr_r;
  assign flash_wr_out = fwr_r;

  // =====================================================================
  // Checks.
  a_stall_on_read: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE11
    tbl_rd_acc |=> cpu_stall_out && flash_rd_req_out)
    else $error("Table read did not stall the core.");

  a_stall_release: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE11
    (state_r == ftab_pkg::FT_ST_TRD) && flash_rvalid_in |=> !cpu_stall_out)
    else $error("Stall held after table read data arrived.");

  a_latch_byte_pick: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE23
    (state_r == ftab_pkg::FT_ST_TRD) && flash_rvalid_in |=> table_byte_latch_out ==
    ($past(bsel_r) ? $past(flash_rdata_in[15:8]) : $past(flash_rdata_in[7:0])))
    else $error("Latch got the wrong byte of the word.");

  a_read_full_addr: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE7
    tbl_rd_acc && (tbl_req_in.mode == ftab_pkg::FT_PM_NONE) |=>
    flash_rd_addr_out == $past(ptr_r[`FT_PTR_W-1:1]))
    else $error("Table read address lost pointer bits.");

  a_bit21_kept: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE21
    tbl_acc |=> table_byte_pointer_out[`FT_SPACE_BIT] == $past(ptr_r[`FT_SPACE_BIT]))
    else $error("Pointer stepping changed the space bit.");

  a_nvdata_hold: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE18
    !((state_r == ftab_pkg::FT_ST_NRD) && flash_rvalid_in) &&
    !(sfr_wr_in.en && sfr_wr_in.sel == ftab_pkg::FT_SEL_DATA_LOW) |=> $stable(nv_data_r))
    else $error("Data register changed without a read or write.");

  a_read_done: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE20
    (state_r == ftab_pkg::FT_ST_NRD) && flash_rvalid_in |=> !nv_go_out && nv_done_irq_flag_out)
    else $error("Byte read completion not signalled.");

  a_dfm_pgread_err: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE19
    go_acc && is_dfm && (nv_cmd_r == `FT_CMD_PAGE_READ) |=> nv_write_error_out && !nv_go_out)
    else $error("Page read to data flash not refused.");

  a_page_base: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE9
    flash_wr_out.en && !flash_wr_out.erase |->
    flash_wr_out.addr[`FT_PTR_W-1:`FT_PAGE_AW] == nv_addr_r[`FT_PTR_W-1:`FT_PAGE_AW])
    else $error("Page write left the selected page.");

  a_table_no_flash: assert property (@(posedge clk_in) disable iff (rst_in) // see RULE3
    tbl_wr_acc |=> !flash_wr_out.en)
    else $error("Table write reached the flash array.");

endmodule // ftab_core
`default_nettype wire

/* File: tb/ftab_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftab_map.svh"

// =====================================================================
// Flash array model: answers each word read after lat_in cycles.
module ftab_flash_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] lat_in,
  input wire logic rd_req_in,
  input wire logic [`FT_PTR_W-2:0] rd_addr_in,
  output logic [`FT_WORD_W-1:0] rdata_out,
  output logic rvalid_out
);
  logic [3:0] cnt_r;
  logic [`FT_PTR_W-2:0] addr_r;
  logic [`FT_WORD_W-1:0] last_r;

  // Contents are a fixed mix of the word address bits.
  function automatic logic [15:0] word_at(input logic [20:0] a);
    return a[15:0] ^ {a[20:16], 11'h4C3};
  endfunction

  // Count down the chosen latency; lat_in must be at least one.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      last_r <= 16'h0000;
    end else begin
      last_r <= rdata_out;
      if (rd_req_in) begin
        cnt_r <= lat_in;
        addr_r <= rd_addr_in;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // Outside the valid cycle the lines toggle so stale data never looks right.
  assign rvalid_out = (cnt_r == 4'h1);
  assign rdata_out = rvalid_out ? word_at(addr_r) : ~last_r;
endmodule // ftab_flash_model
`default_nettype wire

/* File: tb/tb_ftab_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftab_map.svh"

// =====================================================================
// Bench driving table and NVM register traffic into the access path.
module tb_ftab_core;
  localparam logic [21:0] TP [0:5] = '{22'h000000, 22'h1ABCD1, 22'h3FFFFF,
                                       22'h200000, 22'h12344F, 22'h0FFFFE};
  localparam logic [1:0] TM [0:5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [3:0] TL [0:5] = '{4'h1, 4'h5, 4'h3, 4'h2, 4'h1, 4'h4};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  ftab_pkg::ftab_tbl_req_t tbl_req = '0;
  ftab_pkg::ftab_sfr_wr_t sfr_wr = '0;
  ftab_pkg::ftab_flash_wr_t fwr;
  ftab_pkg::ftab_flash_wr_t wl;
  logic flag_clr = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [15:0] rdata;
  logic rvalid, stall, rd_req, go, flag, err, pg;
  logic [7:0] latch, ndat;
  logic [21:0] ptr, nadr, pbase, a;
  logic [20:0] rd_addr, np;
  logic [2:0] ncmd;
  logic [7:0] wmem [0:255];
  int n_fail = 0;
  int samples_checked = 0;
  int nwr = 0;
  int k;

  // Clock at 100 MHz.
  always #5 clk_in = ~clk_in;

  ftab_core u_ftab_core (.clk_in(clk_in), .rst_in(rst_in), .tbl_req_in(tbl_req),
    .sfr_wr_in(sfr_wr), .flag_clr_in(flag_clr), .flash_rdata_in(rdata),
    .flash_rvalid_in(rvalid), .cpu_stall_out(stall), .table_byte_latch_out(latch),
    .table_byte_pointer_out(ptr), .nv_address_reg_out(nadr), .nv_data_low_reg_out(ndat),
    .nv_command_field_out(ncmd), .nv_go_out(go), .nv_done_irq_flag_out(flag),
    .nv_write_error_out(err), .flash_rd_req_out(rd_req), .flash_rd_addr_out(rd_addr),
    .flash_wr_out(fwr));

  ftab_flash_model u_ftab_flash_model (.clk_in(clk_in), .rst_in(rst_in), .lat_in(lat),
    .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rdata_out(rdata), .rvalid_out(rvalid));

  // Records every byte sent toward flash; page writes must run in order.
  always @(posedge clk_in) begin
    if (fwr.en === 1'b1) begin
      if (pg) chk({fwr.erase, fwr.addr}, {1'b0, pbase[21:8], nwr[7:0]});
      wmem[fwr.addr[7:0]] = fwr.data;
      wl = fwr;
      nwr++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One register write, held for a single sampling edge.
  task automatic sfr(input logic [3:0] sel, input logic [7:0] d);
    @(posedge clk_in);
    sfr_wr <= '{1'b1, ftab_pkg::ftab_sel_t'(sel), d};
    @(posedge clk_in);
    sfr_wr <= '0;
    #1;
  endtask

  // Loads a 22-bit pointer through three byte registers starting at sel.
  task automatic set3(input logic [3:0] sel, input logic [21:0] v);
    sfr(sel, v[7:0]);
    sfr(sel + 4'h1, v[15:8]);
    sfr(sel + 4'h2, {2'h0, v[21:16]});
  endtask

  // Waits, bounded, until neither stall nor the start bit is high.
  task automatic settle(input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk_in);
      #1;
      cyc++;
    end while ((stall !== 1'b0 || go !== 1'b0) && cyc < lim);
    if (cyc >= lim) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic tbl(input logic w, input logic [1:0] m);
    @(posedge clk_in);
    tbl_req <= '{1'b1, w, ftab_pkg::ftab_pmode_t'(m)};
    @(posedge clk_in);
    tbl_req <= '0;
    #1;
    if (!w) settle(40, k);
  endtask

  // Model contents as seen at a byte address; odd picks the high byte.
  function automatic logic [7:0] exp_byte(input logic [21:0] p);
    logic [15:0] w;
    w = p[16:1] ^ {p[21:17], 11'h4C3};
    return p[0] ? w[15:8] : w[7:0];
  endfunction

  // Main sequence.
  initial begin
    pg = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({latch, ndat, ncmd, stall, go, flag, err}, 32'h0);
    chk(ptr, 22'h0);
    chk(nadr, 22'h0);
    // Table reads over boundaries, latencies and every stepping mode.
    for (int i = 0; i < 6; i++) begin
      lat <= TL[i];
      set3(4'h1, TP[i]);
      tbl(1'b0, TM[i]);
      np = (TM[i] == 2'h2) ? TP[i][20:0] - 21'h1 :
           (TM[i] == 2'h0) ? TP[i][20:0] : TP[i][20:0] + 21'h1;
      a = (TM[i] == 2'h3) ? {TP[i][21], np} : TP[i];
      chk(latch, exp_byte(a));
      chk(ptr, {TP[i][21], np});
    end
    // Table writes fill the buffer only; data bytes, no instruction words.
    nwr = 0;
    sfr(4'h0, 8'h5A);
    chk(latch, 8'h5A);
    set3(4'h1, 22'h3FFF05);
    tbl(1'b1, 2'h1);
    chk(ptr, 22'h3FFF06);
    sfr(4'h0, 8'hC3);
    tbl(1'b1, 2'h0);
    sfr(4'h0, 8'h77);
    set3(4'h1, 22'h000005);
    tbl(1'b1, 2'h3);
    sfr(4'h0, 8'h99);
    set3(4'h1, 22'h0000FF);
    tbl(1'b1, 2'h2);
    chk(ptr, 22'h0000FE);
    chk(nwr, 0);
    // Page write commits the whole buffer at the upper address bits.
    pbase = 22'h0123AB;
    set3(4'h4, pbase);
    sfr(4'h8, 8'h05);
    pg = 1'b1;
    sfr(4'h9, 8'h01);
    settle(400, k);
    // The last byte leaves the design as the start bit falls; let the monitor see it.
    @(posedge clk_in);
    #1;
    pg = 1'b0;
    chk(nwr, 256);
    chk({wmem[8'h05], wmem[8'h06], wmem[8'hFF]}, 24'h5A7799);
    chk(flag, 1'b1);
    @(posedge clk_in);
    flag_clr <= 1'b1;
    @(posedge clk_in);
    flag_clr <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(flag, 1'b0);
    // Data flash byte reads, plain and post-increment.
    a = 22'h380011;
    lat <= 4'h2;
    set3(4'h4, a);
    for (int c = 0; c < 2; c++) begin
      sfr(4'h8, c[7:0]);
      sfr(4'h9, 8'h01);
      settle(50, k);
      chk({flag, ndat}, {1'b1, exp_byte(a)});
      a = a + c;
      chk(nadr, a);
    end
    // The last read fetched 380011 before the address stepped; a table read must not disturb it.
    tbl(1'b0, 2'h0);
    chk(ndat, exp_byte(22'h380011));
    // Data flash byte write: erase then program, timed internally.
    nwr = 0;
    sfr(4'h7, 8'hE1);
    sfr(4'h8, 8'h03);
    sfr(4'h9, 8'h01);
    settle(1100, k);
    chk(k, `FT_DFM_WR_CYC + 1);
    chk(nwr, 1);
    chk({wl.erase, wl.addr, wl.data}, {1'b1, a, 8'hE1});
    chk(ndat, 8'hE1);
    // Page read aimed at data flash is refused with an error.
    sfr(4'h8, 8'h02);
    sfr(4'h9, 8'h01);
    repeat (2) @(posedge clk_in);
    #1;
    chk({go, err}, 2'b01);
    tally_and_finish();
  end
endmodule // tb_ftab_core
`default_nettype wire
